// ==== design/urx_cfg.svh ====
// urx_cfg.svh: offsets, field positions, reset values and timing counts of the receiver
// assumes: included by its bare name from every design file that needs a number
`ifndef URX_CFG_SVH
`define URX_CFG_SVH

// clock and default line rate; the divisor is derived, not typed in
`define URX_CLK_HZ 40000000
`define URX_BAUD_DEFAULT 9600
`define URX_OVERSAMPLE 16
`define URX_DIV_W 13
`define URX_DIV_RESET 13'((`URX_CLK_HZ) / (`URX_OVERSAMPLE * `URX_BAUD_DEFAULT))

// register word index on the bus (byte address is four times this)
`define URX_REG_CTRL 3'h0
`define URX_REG_DIV 3'h1
`define URX_REG_STAT 3'h2
`define URX_REG_DATA 3'h3
`define URX_REG_IST 3'h4
`define URX_REG_IMSK 3'h5

// control fields
`define URX_CTRL_EN 0
`define URX_CTRL_NINE 1
`define URX_CTRL_RESET 2'h0

// status / interrupt field positions (same layout in status, sticky and mask)
`define URX_F_FULL 0
`define URX_F_FE 1
`define URX_F_NF 2
`define URX_F_ACT 3
`define URX_IRQ_W 3

// oversample tick positions inside one bit time
`define URX_RT1 5'd1
`define URX_RT3 5'd3
`define URX_RT5 5'd5
`define URX_RT7 5'd7
`define URX_RT8 5'd8
`define URX_RT9 5'd9
`define URX_RT10 5'd10
`define URX_RT11 5'd11
`define URX_RT16 5'd16

// last data bit index for each character length
`define URX_LAST8 4'd7
`define URX_LAST9 4'd8

`endif

// ==== design/urx_pkg.sv ====
// urx_pkg: types shared by the receiver files
// assumes: numbers live in urx_cfg.svh
`default_nettype none
package urx_pkg;

  typedef enum logic [1:0] {
    URX_SEARCH = 2'b00,
    URX_START = 2'b01,
    URX_DATA = 2'b10,
    URX_STOP = 2'b11
  } urx_state_e;

  // software control fields
  typedef struct packed {
    logic nine_bit;
    logic enable;
  } urx_ctrl_s;

  // per-frame flags delivered together with the data
  typedef struct packed {
    logic noise_flag;
    logic framing_error_flag;
    logic receive_full_flag;
  } urx_flags_s;

endpackage
`default_nettype wire

// ==== design/urx_rx_recovery.sv ====
// urx_rx_recovery: receive data recovery of an asynchronous serial line, with an
// Avalon-MM register slave and one level interrupt
// assumes: rx_pin is asynchronous to clk_sys; a single Avalon master with word addresses
`timescale 1ns/1ps
`default_nettype none
`include "urx_cfg.svh"

// Function
// - all line sampling is timed by an oversample tick at sixteen times the baud rate.
// - the tick counter phase restarts at each start bit found.
// - the counter realigns when a bit voting 1 is followed by a bit voting 0.
// - a start bit is a low sample after three highs, and from it the counter runs to 16.
// - samples 3, 5, 7 verify the start: at most one high passes, one high sets noise.
// - a failed start resets the counter and restarts the search with no noise flag.
// - each data bit is the majority of samples 8, 9, 10, and disagreement sets noise.
// - in a verified start bit, samples 8 to 10 only set noise when high; the bit stays low.
// - the stop bit is voted from samples 8 to 10: low sets framing error, disagreement noise.
// - noise before a start bit is found never sets the noise flag.
// - framing error appears in the same cycle as receive full for that frame.
// - a break with no high stop bit sets the framing error flag.
// - a falling edge after a bit voting 1 realigns the counter to correct drift, except on samples 8 to 10.
// - eight or nine data bits are taken as chosen, the ninth shown as bit eight.
// - a finished frame moves to the data register and sets receive full.
module urx_rx_recovery (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic rx_pin,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);

  // majority of three samples
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // true when three samples are not all equal
  function automatic logic split3(input logic a, input logic b, input logic c);
    split3 = !((a == b) && (b == c));
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [2:0] rx_sync_q;
  logic smp_q;
  urx_pkg::urx_ctrl_s ctrl_q;
  logic [`URX_DIV_W-1:0] div_q;
  logic tick;
  urx_pkg::urx_state_e state_q;
  logic [4:0] rt_q;
  logic [2:0] hist_q;
  logic [3:0] bit_q;
  logic [8:0] shift_q;
  logic v3_q, v5_q, s8_q, s9_q;
  logic last_one_q;
  logic frame_nf_q;
  logic [8:0] data_q;
  urx_pkg::urx_flags_s flags_q;
  logic [`URX_IRQ_W-1:0] ist_q;
  logic [`URX_IRQ_W-1:0] imsk_q;
  logic [`URX_IRQ_W-1:0] ist_clr_w, ist_set_w;
  logic [31:0] rdata_d;
  logic fall_w, vote_w, split_w, done_w, boundary_w;
  logic [1:0] ones_w;
  logic [3:0] last_bit_w;
  logic wr_go, rd_go, data_rd;
  logic [31:0] ctrl_word, div_word;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // line synchroniser: the level moves only when the second and third stages agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync_q <= 3'h7;
      smp_q <= 1'b1;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], rx_pin};
      if (rx_sync_q[1] == rx_sync_q[2]) begin
        smp_q <= rx_sync_q[2];
      end
    end
  end

  urx_tick_div u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .enable(ctrl_q.enable),
    .divisor(div_q),
    .oversample_tick(tick)
  );

  // sample decoding shared by every state
  assign fall_w = !smp_q && (hist_q == 3'h7);
  assign ones_w = 2'(v3_q) + 2'(v5_q) + 2'(smp_q);
  assign vote_w = maj3(s8_q, s9_q, smp_q);
  assign split_w = split3(s8_q, s9_q, smp_q);
  assign last_bit_w = ctrl_q.nine_bit ? `URX_LAST9 : `URX_LAST8;
  // an edge after a 1 bit, late in that bit, marks the start of the next one
  assign boundary_w = (rt_q == `URX_RT16) ||
                      (fall_w && last_one_q && (rt_q >= `URX_RT11));
  assign done_w = tick && (state_q == urx_pkg::URX_STOP) && (rt_q == `URX_RT10);

  // frame state machine, stepped only on the oversample tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= urx_pkg::URX_SEARCH;
      rt_q <= 5'h0;
      hist_q <= 3'h0;
      bit_q <= 4'h0;
      last_one_q <= 1'b0;
    end else if (!ctrl_q.enable) begin
      state_q <= urx_pkg::URX_SEARCH;
      rt_q <= 5'h0;
      hist_q <= 3'h0;
      bit_q <= 4'h0;
      last_one_q <= 1'b0;
    end else if (tick) begin
      hist_q <= {hist_q[1:0], smp_q};
      rt_q <= (rt_q == `URX_RT16) ? `URX_RT1 : rt_q + 5'h1;
      case (state_q)
        urx_pkg::URX_SEARCH: begin
          rt_q <= 5'h0;
          if (fall_w) begin
            state_q <= urx_pkg::URX_START;
            rt_q <= `URX_RT1;
          end
        end
        urx_pkg::URX_START: begin
          if (rt_q == `URX_RT7 && ones_w >= 2'd2) begin
            state_q <= urx_pkg::URX_SEARCH;
            rt_q <= 5'h0;
            hist_q <= 3'h0; // a new edge needs three fresh highs
          end else if (rt_q == `URX_RT16) begin
            state_q <= urx_pkg::URX_DATA;
            bit_q <= 4'h0;
            last_one_q <= 1'b0; // start bit always counts as low
          end
        end
        urx_pkg::URX_DATA: begin
          if (rt_q == `URX_RT10) begin
            last_one_q <= vote_w;
          end
          if (boundary_w) begin
            rt_q <= `URX_RT1;
            last_one_q <= (rt_q == `URX_RT16) ? last_one_q : 1'b0;
            if (bit_q == last_bit_w) begin
              state_q <= urx_pkg::URX_STOP;
            end else begin
              bit_q <= bit_q + 4'h1;
            end
          end else if (fall_w && last_one_q && rt_q <= `URX_RT7) begin
            rt_q <= `URX_RT1; // early edge of this bit
          end
        end
        urx_pkg::URX_STOP: begin
          if (fall_w && last_one_q && rt_q <= `URX_RT7) begin
            rt_q <= `URX_RT1;
          end else if (rt_q == `URX_RT10) begin
            state_q <= urx_pkg::URX_SEARCH; // hunt for the next start right away
            rt_q <= 5'h0;
            last_one_q <= 1'b0;
          end
        end
        default: begin
          state_q <= urx_pkg::URX_SEARCH;
          rt_q <= 5'h0;
        end
      endcase
    end
  end

  // verification and vote samples
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      v3_q <= 1'b0;
      v5_q <= 1'b0;
      s8_q <= 1'b0;
      s9_q <= 1'b0;
    end else if (tick) begin
      if (rt_q == `URX_RT3) begin
        v3_q <= smp_q;
      end
      if (rt_q == `URX_RT5) begin
        v5_q <= smp_q;
      end
      if (rt_q == `URX_RT8) begin
        s8_q <= smp_q;
      end
      if (rt_q == `URX_RT9) begin
        s9_q <= smp_q;
      end
    end
  end

  // data shift register, lsb first; shifts on the vote of each data bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 9'h0;
    end else if (tick && state_q == urx_pkg::URX_DATA && rt_q == `URX_RT10) begin
      shift_q <= {vote_w, shift_q[8:1]};
    end
  end

  // frame noise: cleared when a start is found, so glitches while hunting never count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_nf_q <= 1'b0;
    end else if (tick) begin
      case (state_q)
        urx_pkg::URX_SEARCH: begin
          frame_nf_q <= 1'b0;
        end
        urx_pkg::URX_START: begin
          if (rt_q == `URX_RT7 && ones_w == 2'd1) begin
            frame_nf_q <= 1'b1;
          end
          if (rt_q >= `URX_RT8 && rt_q <= `URX_RT10 && smp_q) begin
            frame_nf_q <= 1'b1;
          end
        end
        urx_pkg::URX_DATA: begin
          if (rt_q == `URX_RT10 && split_w) begin
            frame_nf_q <= 1'b1;
          end
        end
        default: begin
          frame_nf_q <= frame_nf_q;
        end
      endcase
    end
  end

  // bus handshake: waitrequest drops for one cycle on each request, which takes it
  assign wr_go = avs_write && !avs_waitrequest;
  assign rd_go = avs_read && !avs_waitrequest;
  assign data_rd = rd_go && (avs_address == `URX_REG_DATA);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rdata_d;
      end
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    rdata_d = 32'h0;
    case (avs_address)
      `URX_REG_CTRL: rdata_d = ctrl_word;
      `URX_REG_DIV: rdata_d = div_word;
      `URX_REG_STAT: begin
        rdata_d[`URX_F_FULL] = flags_q.receive_full_flag;
        rdata_d[`URX_F_FE] = flags_q.framing_error_flag;
        rdata_d[`URX_F_NF] = flags_q.noise_flag;
        rdata_d[`URX_F_ACT] = (state_q != urx_pkg::URX_SEARCH);
      end
      `URX_REG_DATA: rdata_d[8:0] = data_q;
      `URX_REG_IST: rdata_d[`URX_IRQ_W-1:0] = ist_q;
      `URX_REG_IMSK: rdata_d[`URX_IRQ_W-1:0] = imsk_q;
      default: rdata_d = 32'h0;
    endcase
  end

  assign ctrl_word = {30'h0, ctrl_q.nine_bit, ctrl_q.enable};
  assign div_word = {{(32 - `URX_DIV_W){1'b0}}, div_q};

  // software control registers; a character length change is meant for an idle line
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= urx_pkg::urx_ctrl_s'(`URX_CTRL_RESET);
      div_q <= `URX_DIV_RESET;
      imsk_q <= '0;
    end else if (wr_go) begin
      case (avs_address)
        `URX_REG_CTRL: ctrl_q <= urx_pkg::urx_ctrl_s'(2'(
                          merge(ctrl_word, avs_writedata, avs_byteenable)
                          >> `URX_CTRL_EN));
        `URX_REG_DIV: div_q <= `URX_DIV_W'(merge(div_word, avs_writedata, avs_byteenable));
        `URX_REG_IMSK: begin
          if (avs_byteenable[0]) begin
            imsk_q <= avs_writedata[`URX_IRQ_W-1:0];
          end
        end
        default: begin
          imsk_q <= imsk_q;
        end
      endcase
    end
  end

  // receive data and frame flags; a new frame beats the clear of a data read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= 9'h0;
      flags_q <= '0;
    end else if (done_w) begin
      data_q <= ctrl_q.nine_bit ? shift_q : {1'b0, shift_q[8:1]};
      flags_q.receive_full_flag <= 1'b1;
      flags_q.framing_error_flag <= !vote_w;
      flags_q.noise_flag <= frame_nf_q || split_w;
    end else if (data_rd) begin
      flags_q <= '0;
    end
  end

  // event decode: clear from a lane-0 write, set from a finished frame
  always_comb begin
    ist_clr_w = '0;
    ist_set_w = '0;
    if (wr_go && avs_address == `URX_REG_IST && avs_byteenable[0]) begin
      ist_clr_w = avs_writedata[`URX_IRQ_W-1:0];
    end
    if (done_w) begin
      ist_set_w[`URX_F_FULL] = 1'b1;
      ist_set_w[`URX_F_FE] = !vote_w;
      ist_set_w[`URX_F_NF] = frame_nf_q || split_w;
    end
  end

  // sticky event bits, write one to clear; a same-cycle event wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ist_q <= '0;
    end else begin
      ist_q <= (ist_q & ~ist_clr_w) | ist_set_w;
    end
  end

  // one level interrupt while any unmasked sticky bit is set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_q & imsk_q);
    end
  end

endmodule
`default_nettype wire

// ==== design/urx_tick_div.sv ====
// urx_tick_div: divides the system clock down to the oversample tick
// assumes: one clock; divisor comes from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "urx_cfg.svh"

module urx_tick_div (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [`URX_DIV_W-1:0] divisor,
  output logic oversample_tick
);

  logic [`URX_DIV_W-1:0] cnt_q;

  // down counter; a divisor of zero behaves as one so the tick never stops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      oversample_tick <= 1'b0;
    end else if (!enable) begin
      cnt_q <= '0;
      oversample_tick <= 1'b0;
    end else if (cnt_q == '0) begin
      cnt_q <= (divisor == '0) ? '0 : divisor - `URX_DIV_W'(1);
      oversample_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q - `URX_DIV_W'(1);
      oversample_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== tb/tb_uart_rx_data_recovery.sv ====
// tb_uart_rx_data_recovery: self-checking bench for the serial receiver
// assumes: divisor set to 2, so one bit lasts 32 clocks
`timescale 1ns/1ps
`default_nettype none
`include "urx_cfg.svh"
module tb_uart_rx_data_recovery;
  logic clk_sys, reset_n, go, busy, rx_pin, irq, avs_read, avs_write, avs_waitrequest;
  logic [2:0] avs_address, g_w;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, nb;
  logic [11:0] fr;
  logic [6:0] bclk;
  logic [9:0] g_at;
  int n_errors = 0;
  int n_compared = 0;
  urx_rx_recovery dut (.clk_sys(clk_sys), .reset_n(reset_n), .rx_pin(rx_pin),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
  urx_tx_model far (.clk_sys(clk_sys), .reset_n(reset_n), .go(go), .frame(fr),
    .n_bits(nb), .bclk(bclk),
    .g_at(g_at), .g_w(g_w), .rx_line(rx_pin), .busy(busy));
  // 40 MHz
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  function automatic logic [11:0] mk(input logic [8:0] d, input logic nine, input logic sb);
    return nine ? {1'b1, sb, d, 1'b0} : {2'b11, sb, d[7:0], 1'b0};
  endfunction
  function automatic logic [31:0] stat(input logic nf, input logic fe);
    return {29'h0, nf, fe, 1'b1};
  endfunction
  task automatic send(input logic [11:0] f, input logic [3:0] n, input logic [6:0] b,
    input logic [9:0] ga, input logic [2:0] gw);
    fr <= f;
    nb <= n;
    bclk <= b;
    g_at <= ga;
    g_w <= gw;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    while (busy) @(posedge clk_sys);
    repeat (48) @(posedge clk_sys);
  endtask
  // status, data, then status again since the data read clears the flags
  task automatic rx_check(input logic [8:0] d, input logic [31:0] st, input logic [31:0] m);
    bus(1'b0, `URX_REG_STAT, 32'h0);
    chk("status", st & m, rd & m);
    bus(1'b0, `URX_REG_DATA, 32'h0);
    chk("data", {23'h0, d}, rd);
    bus(1'b0, `URX_REG_STAT, 32'h0);
    chk("status cleared", 32'h0, rd & 32'h7);
  endtask
  // main sequence
  initial begin
    logic [8:0] d;
    int k;
    int gp[3] = '{8, 16, 304};
    int gw[3] = '{4, 2, 2};
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    go = 1'b0;
    fr = 12'hfff;
    nb = 4'h0;
    bclk = 7'd32;
    g_at = 10'h0;
    g_w = 3'h0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    void'($urandom(77));
    bus(1'b0, `URX_REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    bus(1'b0, `URX_REG_DIV, 32'h0);
    chk("divisor reset", 32'(`URX_DIV_RESET), rd);
    bus(1'b0, `URX_REG_IMSK, 32'h0);
    chk("mask reset", 32'h0, rd);
    bus(1'b0, 3'h7, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, `URX_REG_DIV, 32'h2);
    bus(1'b1, `URX_REG_CTRL, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 9'h0ff : 9'($urandom_range(0, 255));
      send(mk(d, 1'b0, 1'b1), 4'd10, 7'd32, 10'h0, 3'h0);
      rx_check(d, stat(1'b0, 1'b0), 32'hf);
      d = (i == 6) ? 9'h100 : d | 9'($urandom_range(0, 1) << 8);
      // nine-bit frames only while nine-bit mode is on, eight-bit ones only while off
      if (i > 5) begin
        bus(1'b1, `URX_REG_CTRL, 32'h3);
        send(mk(d, 1'b1, 1'b1), 4'd11, 7'd32, 10'h0, 3'h0);
        rx_check(d, stat(1'b0, 1'b0), 32'hf);
        bus(1'b1, `URX_REG_CTRL, 32'h1);
      end
    end
    bus(1'b1, `URX_REG_CTRL, 32'h1);
    $display("test clean frames done");
    for (int i = 0; i < 4; i++) begin
      d = 9'($urandom_range(0, 255));
      k = $urandom_range(1, 8);
      send(mk(d, 1'b0, 1'b1), 4'd10, 7'd32, 10'(32 * k + 16), 3'h2);
      rx_check(d, stat(1'b1, 1'b0), 32'hf);
      send(mk(d, 1'b0, 1'b1), 4'd10, 7'd32, 10'(gp[i % 3]), 3'(gw[i % 3]));
      rx_check(d, stat(1'b1, 1'b0), 32'hf);
    end
    $display("test noise done");
    send(mk(9'h0, 1'b0, 1'b0), 4'd10, 7'd32, 10'h0, 3'h0);
    rx_check(9'h0, stat(1'b0, 1'b1), 32'h7);
    send(12'hfff, 4'd2, 7'd32, 10'd40, 3'h4);
    bus(1'b0, `URX_REG_STAT, 32'h0);
    chk("status after glitch", 32'h0, rd & 32'hf);
    send(mk(9'h3c, 1'b0, 1'b1), 4'd10, 7'd32, 10'h0, 3'h0);
    rx_check(9'h3c, stat(1'b0, 1'b0), 32'hf);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `URX_REG_CTRL, 32'(1 + 2 * (i / 2)));
      d = (i > 1) ? 9'h155 : 9'h055;
      send(mk(d, i > 1, 1'b1), 4'(10 + i / 2), 7'(30 + 4 * (i % 2)), 10'h0, 3'h0);
      rx_check(d, stat(1'b0, 1'b0), 32'h3);
    end
    bus(1'b1, `URX_REG_CTRL, 32'h1);
    $display("test drift done");
    bus(1'b1, `URX_REG_IST, 32'h7);
    send(mk(9'h81, 1'b0, 1'b0), 4'd10, 7'd32, 10'h0, 3'h0);
    bus(1'b0, `URX_REG_IST, 32'h0);
    chk("events", 32'h3, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, i[0] ? `URX_REG_IST : `URX_REG_IMSK, 32'(i == 0 ? 6 : (i == 2 ? 4 : 2)));
      @(posedge clk_sys);
      chk("irq", 32'(i == 0), {31'h0, irq});
    end
    $display("test interrupt done");
    end_sim;
  end
  // hang guard, well beyond the expected run length
  initial begin
    #(25 * 60000);
    n_errors++;
    $display("ERROR watchdog expected %s seen %s", "finish", "hang");
    end_sim;
  end
endmodule
bind urx_rx_recovery urx_rx_recovery_properties u_props (.clk_sys(clk_sys),
  .reset_n(reset_n), .rx_pin(rx_pin), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
`default_nettype wire

// ==== tb/urx_rx_recovery_properties.sv ====
// urx_rx_recovery_properties: bus and interrupt checks on the receiver's ports
// assumes: bound to urx_rx_recovery; one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "urx_cfg.svh"
module urx_rx_recovery_properties (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic rx_pin,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // every request costs exactly one wait cycle
  chk_one_wait:
  assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait");
  chk_wait_pulse:
  assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_idle_wait:
  assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  chk_unmapped_zero:
  assert property (avs_read && !avs_waitrequest && avs_address > `URX_REG_IMSK
    |-> avs_readdata == 32'h0) else $error("unmapped word not zero");
  chk_data_width:
  assert property (avs_read && !avs_waitrequest && avs_address == `URX_REG_DATA
    |-> avs_readdata[31:9] == 23'h0) else $error("data word too wide");
  chk_stat_width:
  assert property (avs_read && !avs_waitrequest && avs_address == `URX_REG_STAT
    |-> avs_readdata[31:4] == 28'h0) else $error("status word too wide");
  // read data only moves when a new read is latched
  chk_read_hold:
  assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved");
  // the level only drops after a register write
  chk_irq_clear:
  assert property ($fell(irq) |-> $past(avs_write && !avs_waitrequest, 2))
    else $error("irq dropped without write");
endmodule
`default_nettype wire

// ==== tb/urx_tx_model.sv ====
// urx_tx_model: remote transmitter driving the receive line
// assumes: go pulses one clock with the frame fields already set
`timescale 1ns/1ps
`default_nettype none
module urx_tx_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [11:0] frame,
  input wire logic [3:0] n_bits,
  input wire logic [6:0] bclk,
  input wire logic [9:0] g_at,
  input wire logic [2:0] g_w,
  output logic rx_line,
  output logic busy
);
  int cnt;
  // bit timer; busy is its own flop so a longer next frame never revives a parked count
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      busy <= 1'b0;
    end else if (go && !busy) begin
      cnt <= 0;
      busy <= 1'b1;
    end else if (busy) begin
      cnt <= cnt + 1;
      busy <= (cnt + 1) < int'(n_bits) * int'(bclk);
    end
  end
  // lsb first; mark level between frames so a start sees three highs, burst inverts
  always_comb begin
    rx_line = 1'b1;
    if (busy) begin
      rx_line = frame[cnt / int'(bclk)];
      if (cnt >= int'(g_at) && cnt < int'(g_at) + int'(g_w)) begin
        rx_line = ~rx_line;
      end
    end
  end
endmodule
`default_nettype wire
